// *** pkg/hsp_regs.vh ***
// register map, field positions and timing counts of the serial port block
// assumes inclusion by the design, checker and bench files; definitions only
`ifndef HSP_REGS_VH
`define HSP_REGS_VH
// register indices on the 4-bit address bus
`define HSP_ADDR_FIFO_STATUS 4'h0
`define HSP_ADDR_BYTE_PORT 4'h1
`define HSP_ADDR_CONTROL 4'h2
`define HSP_ADDR_TIMING 4'h3
`define HSP_ADDR_WATCHDOG 4'h4
// control register fields
`define HSP_CTRL_FILL_HI 3
`define HSP_CTRL_FILL_LO 2
`define HSP_CTRL_RESET 8'h00
// timing control register fields
`define HSP_TIM_IC_BIT 6
`define HSP_TIM_BRCK_BIT 4
`define HSP_TIM_TC_HI 3
`define HSP_TIM_TC_LO 0
`define HSP_TIM_RESET 8'h00
// fill select encodings
`define HSP_FILL_IDLE 2'b00
`define HSP_FILL_FLAGS 2'b01
`define HSP_FILL_TRANSP 2'b10
`define HSP_FILL_GOAHEAD 2'b11
// fill patterns sent when not transparent
`define HSP_PAT_IDLE 8'hFF
`define HSP_PAT_FLAG 8'h7E
`define HSP_PAT_GOAHEAD 8'h7F
// watchdog
`define HSP_WD_STAGES 11
`define HSP_WD_KEY 5'h0A
// fifo
`define HSP_FIFO_DEPTH 19
`define HSP_RX_NEAR_FULL 5'd15
`define HSP_TX_NEAR_EMPTY 5'd4
// level status update delays, in falling clock edges
`define HSP_LVL_DLY_2M 3'd2
`define HSP_LVL_DLY_4M 3'd4
// internal timing slot start within the frame, in bits
`define HSP_SLOT_START 8'd16
`endif

// *** design/hsp_top.v ***
// serial port, transparent byte transfer, watchdog and fifo status of a framing controller
// assumes a byte-wide e-clock bus and serial pins all asynchronous to mclk (40 MHz)
`timescale 1ns/1ps
`include "hsp_regs.vh"

module hsp_fifo #(
  parameter W = 8,
  parameter D = 19,
  parameter AW = 5
) (
  input wire mclk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW-1:0] count
);
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW-1:0] cnt_ff;
  wire do_wr;
  wire do_rd;

  assign in_ready = (cnt_ff != D[AW-1:0]);
  assign out_valid = (cnt_ff != {AW{1'b0}});
  assign out_data = mem_ff[rd_ff];
  assign count = cnt_ff;
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      bump = (p == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge mclk) begin
    if (!rstn) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {AW{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ff <= bump(wr_ff);
      end
      if (do_rd) begin
        rd_ff <= bump(rd_ff);
      end
      if (do_wr & ~do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // storage has no reset; only the pointers define contents
  always @(posedge mclk) begin
    if (do_wr) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

module hsp_top (
  input wire mclk,
  input wire rstn,
  input wire serial_bit_clock_in,
  input wire bus_clock_2m,
  input wire bus_clock_4m_n,
  input wire frame_pulse_n,
  input wire tx_section_enable_n,
  input wire rx_section_enable_n,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_out_oe,
  output reg watchdog_alarm_n,
  input wire bus_e,
  input wire bus_cs_n,
  input wire bus_rw,
  input wire [3:0] bus_addr,
  input wire [7:0] bus_data_in,
  output reg [7:0] bus_data_out,
  output reg bus_data_oe
);
  // two-flop synchronisers for every pin
  reg [9:0] sa_ff;
  reg [9:0] sb_ff;
  reg [9:0] prev_ff;
  reg [11:0] pa_ff;
  reg [11:0] pb_ff;
  wire s_ck = sb_ff[0];
  wire s_c2 = sb_ff[1];
  wire s_c4n = sb_ff[2];
  wire s_f0n = sb_ff[3];
  wire s_txen_n = sb_ff[4];
  wire s_rxen_n = sb_ff[5];
  wire s_sdi = sb_ff[6];
  wire s_e = sb_ff[7];
  wire s_cs_n = sb_ff[8];
  wire s_rw = sb_ff[9];
  wire [3:0] s_addr = pb_ff[11:8];
  wire [7:0] s_data = pb_ff[7:0];

  always @(posedge mclk) begin
    if (!rstn) begin
      // reset to the idle level of every pin so no false edge follows reset
      sa_ff <= 10'h33C;
      sb_ff <= 10'h33C;
      prev_ff <= 10'h33C;
      pa_ff <= 12'h000;
      pb_ff <= 12'h000;
    end else begin
      sa_ff <= {bus_rw, bus_cs_n, bus_e, serial_data_in, rx_section_enable_n, tx_section_enable_n,
                frame_pulse_n, bus_clock_4m_n, bus_clock_2m, serial_bit_clock_in};
      sb_ff <= sa_ff;
      prev_ff <= sb_ff;
      pa_ff <= {bus_addr, bus_data_in};
      pb_ff <= pa_ff;
    end
  end

  wire ck_rise = s_ck & ~prev_ff[0];
  wire ck_fall = ~s_ck & prev_ff[0];
  wire c2_rise = s_c2 & ~prev_ff[1];
  wire c2_fall = ~s_c2 & prev_ff[1];
  wire c4_rise = ~s_c4n & prev_ff[2];
  wire c4_fall = s_c4n & ~prev_ff[2];
  wire f0_fall = ~s_f0n & prev_ff[3];
  wire e_fall = ~s_e & prev_ff[7];

  // registers
  reg [7:0] ctrl_ff;
  reg [7:0] timing_ff;
  wire [1:0] fill_select = ctrl_ff[`HSP_CTRL_FILL_HI:`HSP_CTRL_FILL_LO];
  wire ic = timing_ff[`HSP_TIM_IC_BIT];
  wire brck = timing_ff[`HSP_TIM_BRCK_BIT];
  wire [3:0] timeslot_width_bits = timing_ff[`HSP_TIM_TC_HI:`HSP_TIM_TC_LO];

  // slot width in bits; code 0 and codes above 8 mean a full byte
  function [3:0] slot_bits;
    input [3:0] tc;
    begin
      slot_bits = (tc == 4'h0 || tc > 4'h8) ? 4'h8 : tc;
    end
  endfunction

  function [1:0] rx_level;
    input [4:0] n;
    begin
      if (n == 5'd0) begin
        rx_level = 2'b00;
      end else if (n == `HSP_FIFO_DEPTH) begin
        rx_level = 2'b10;
      end else if (n >= `HSP_RX_NEAR_FULL) begin
        rx_level = 2'b11;
      end else begin
        rx_level = 2'b01;
      end
    end
  endfunction

  function [1:0] tx_level;
    input [4:0] n;
    begin
      if (n == `HSP_FIFO_DEPTH) begin
        tx_level = 2'b00;
      end else if (n == 5'd0) begin
        tx_level = 2'b10;
      end else if (n <= `HSP_TX_NEAR_EMPTY) begin
        tx_level = 2'b11;
      end else begin
        tx_level = 2'b01;
      end
    end
  endfunction

  wire [3:0] width = ic ? slot_bits(timeslot_width_bits) : 4'h8;
  wire xpar = (fill_select == `HSP_FILL_TRANSP) && !(ic && width == 4'h1);

  // bit clock selection; 4 MHz internal mode halves the clock
  reg div_ff;
  always @(posedge mclk) begin
    if (!rstn) begin
      div_ff <= 1'b0;
    end else if (ic && !brck && c4_rise) begin
      div_ff <= ~div_ff;
    end
  end
  wire tx_edge = ic ? (brck ? c2_rise : (c4_rise & div_ff)) : ck_rise;
  wire rx_edge = ic ? (brck ? c2_fall : (c4_rise & ~div_ff)) : ck_fall;
  wire lvl_edge = ic ? (brck ? c2_fall : c4_fall) : ck_fall;
  wire [2:0] lvl_dly = (ic && !brck) ? `HSP_LVL_DLY_4M : `HSP_LVL_DLY_2M;

  // internal timing slot window
  reg [7:0] frame_bit_ff;
  always @(posedge mclk) begin
    if (!rstn) begin
      frame_bit_ff <= 8'h00;
    end else if (f0_fall) begin
      frame_bit_ff <= 8'h00;
    end else if (tx_edge) begin
      frame_bit_ff <= frame_bit_ff + 8'h01;
    end
  end
  wire in_slot = (frame_bit_ff >= `HSP_SLOT_START) && (frame_bit_ff < `HSP_SLOT_START + {4'h0, width});
  // enables read only at the bit boundary, so mid-bit changes wait for the next bit
  wire tx_en_now = ic ? in_slot : ~s_txen_n;
  wire rx_en_now = ic ? in_slot : ~s_rxen_n;

  // bus access decode on the falling edge of e
  wire access = e_fall & ~s_cs_n;
  wire wr_acc = access & ~s_rw;
  wire rd_pop = access & s_rw & (s_addr == `HSP_ADDR_BYTE_PORT);
  wire wd_clear = wr_acc & (s_addr == `HSP_ADDR_WATCHDOG) & (s_data[4:0] == `HSP_WD_KEY);

  always @(posedge mclk) begin
    if (!rstn) begin
      ctrl_ff <= `HSP_CTRL_RESET;
      timing_ff <= `HSP_TIM_RESET;
    end else if (wr_acc) begin
      if (s_addr == `HSP_ADDR_CONTROL) begin
        ctrl_ff <= s_data;
      end
      if (s_addr == `HSP_ADDR_TIMING) begin
        timing_ff <= s_data;
      end
    end
  end

  // fifos
  wire tx_in_ready;
  wire tx_out_valid;
  wire [7:0] tx_head;
  wire [4:0] tx_count;
  wire rx_in_ready;
  wire rx_out_valid;
  wire [7:0] rx_head;
  wire [4:0] rx_count;
  wire tx_push = wr_acc & (s_addr == `HSP_ADDR_BYTE_PORT);
  reg tx_pop;
  reg rx_push;
  reg [7:0] rx_byte;

  hsp_fifo #(.W(8), .D(`HSP_FIFO_DEPTH), .AW(5)) u_tx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(s_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_head),
    .count(tx_count)
  );

  hsp_fifo #(.W(8), .D(`HSP_FIFO_DEPTH), .AW(5)) u_rx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_byte),
    .out_valid(rx_out_valid),
    .out_ready(rd_pop),
    .out_data(rx_head),
    .count(rx_count)
  );

  // transmit shifter
  reg [7:0] cur_ff;
  reg [7:0] last_ff;
  reg [2:0] tidx_ff;
  reg [7:0] pattern;
  always @* begin
    case (fill_select)
      `HSP_FILL_FLAGS: pattern = `HSP_PAT_FLAG;
      `HSP_FILL_GOAHEAD: pattern = `HSP_PAT_GOAHEAD;
      default: pattern = `HSP_PAT_IDLE;
    endcase
  end
  wire tx_last_bit = ({1'b0, tidx_ff} == width - 4'h1);

  always @* begin
    tx_pop = tx_edge & tx_en_now & tx_last_bit & xpar & tx_out_valid;
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      cur_ff <= `HSP_PAT_IDLE;
      last_ff <= `HSP_PAT_IDLE;
      tidx_ff <= 3'd0;
      serial_data_out <= 1'b1;
      serial_data_out_oe <= 1'b0;
    end else if (tx_edge) begin
      if (tx_en_now) begin
        serial_data_out <= cur_ff[tidx_ff];
        serial_data_out_oe <= 1'b1;
        if (tx_last_bit) begin
          tidx_ff <= 3'd0;
          if (!xpar) begin
            cur_ff <= pattern;
          end else if (tx_out_valid) begin
            cur_ff <= tx_head;
            last_ff <= tx_head;
          end else begin
            cur_ff <= last_ff;
          end
        end else begin
          tidx_ff <= tidx_ff + 3'd1;
        end
      end else begin
        serial_data_out_oe <= 1'b0;
      end
    end
  end

  // receive shifter; right shift leaves a short slot in the upper bits
  reg rx_act_ff;
  reg [7:0] rsh_ff;
  reg [2:0] ridx_ff;
  wire [7:0] rsh_next = {s_sdi, rsh_ff[7:1]};
  wire rx_last_bit = ({1'b0, ridx_ff} == width - 4'h1);

  always @* begin
    rx_byte = rsh_next;
    rx_push = rx_edge & rx_act_ff & rx_last_bit & xpar;
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      rx_act_ff <= 1'b0;
      rsh_ff <= 8'h00;
      ridx_ff <= 3'd0;
    end else begin
      if (tx_edge) begin
        rx_act_ff <= rx_en_now;
      end
      if (rx_edge && rx_act_ff) begin
        if (rx_last_bit) begin
          rsh_ff <= 8'h00;
          ridx_ff <= 3'd0;
        end else begin
          rsh_ff <= rsh_next;
          ridx_ff <= ridx_ff + 3'd1;
        end
      end
    end
  end

  // level snapshots lag each fifo access by a few clock falls so software never sees a torn count
  reg [2:0] rx_pend_ff;
  reg [2:0] tx_pend_ff;
  reg [1:0] rx_lvl_ff;
  reg [1:0] tx_lvl_ff;
  wire rx_touch = rd_pop | (rx_push & rx_in_ready);
  wire tx_touch = (tx_push & tx_in_ready) | tx_pop;

  always @(posedge mclk) begin
    if (!rstn) begin
      rx_pend_ff <= 3'd0;
      tx_pend_ff <= 3'd0;
      rx_lvl_ff <= 2'b00;
      tx_lvl_ff <= 2'b10;
    end else begin
      if (rx_touch) begin
        rx_pend_ff <= lvl_dly;
      end else if (lvl_edge && rx_pend_ff != 3'd0) begin
        rx_pend_ff <= rx_pend_ff - 3'd1;
      end
      if (tx_touch) begin
        tx_pend_ff <= lvl_dly;
      end else if (lvl_edge && tx_pend_ff != 3'd0) begin
        tx_pend_ff <= tx_pend_ff - 3'd1;
      end
      if (rx_pend_ff == 3'd0 && !rx_touch) begin
        rx_lvl_ff <= rx_level(rx_count);
      end
      if (tx_pend_ff == 3'd0 && !tx_touch) begin
        tx_lvl_ff <= tx_level(tx_count);
      end
    end
  end

  // watchdog; a clear in the same cycle as a frame pulse wins
  reg [`HSP_WD_STAGES-1:0] wd_ff;
  always @(posedge mclk) begin
    if (!rstn) begin
      wd_ff <= {`HSP_WD_STAGES{1'b0}};
      watchdog_alarm_n <= 1'b1;
    end else begin
      if (wd_clear) begin
        wd_ff <= {`HSP_WD_STAGES{1'b0}};
      end else if (f0_fall) begin
        wd_ff <= wd_ff + 1'b1;
      end
      watchdog_alarm_n <= ~wd_ff[`HSP_WD_STAGES-1];
    end
  end

  // read data; byte status is always packet byte since framing is bypassed here
  reg [7:0] rd_mux;
  always @* begin
    case (s_addr)
      `HSP_ADDR_FIFO_STATUS: rd_mux = {2'b00, rx_lvl_ff, tx_lvl_ff, 2'b00};
      `HSP_ADDR_BYTE_PORT: rd_mux = rx_head;
      `HSP_ADDR_CONTROL: rd_mux = ctrl_ff;
      `HSP_ADDR_TIMING: rd_mux = timing_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      bus_data_out <= 8'h00;
      bus_data_oe <= 1'b0;
    end else begin
      bus_data_oe <= s_e & ~s_cs_n & s_rw;
      if (s_e && !s_cs_n && s_rw) begin
        bus_data_out <= rd_mux;
      end
    end
  end
endmodule

// *** tb/hsp_properties.sv ***
// checker for the serial port block: reset levels, watchdog, status zeros, serial timing
// assumes bind to hsp_top; pin-level counts lead the design by a few mclk
`timescale 1ns/1ps
`include "hsp_regs.vh"
module hsp_properties (
  input wire mclk,
  input wire rstn,
  input wire serial_bit_clock_in,
  input wire frame_pulse_n,
  input wire tx_section_enable_n,
  input wire serial_data_out,
  input wire serial_data_out_oe,
  input wire watchdog_alarm_n,
  input wire bus_e,
  input wire bus_cs_n,
  input wire bus_rw,
  input wire [3:0] bus_addr,
  input wire [7:0] bus_data_in,
  input wire [7:0] bus_data_out,
  input wire bus_data_oe
);
  reg [11:0] wd_cnt_ff;
  reg [5:0] rise_age_ff;
  reg [1:0] off_bits_ff;
  reg fp_ff;
  reg e_ff;
  reg ck_ff;
  wire ck_rise = serial_bit_clock_in && !ck_ff;
  always @(posedge mclk) begin
    fp_ff <= frame_pulse_n;
    e_ff <= bus_e;
    ck_ff <= serial_bit_clock_in;
    if (!rstn) begin
      wd_cnt_ff <= 12'h000;
      rise_age_ff <= 6'h3f;
      off_bits_ff <= 2'h0;
    end else begin
      if (e_ff && !bus_e && !bus_cs_n && !bus_rw && bus_addr == `HSP_ADDR_WATCHDOG && bus_data_in[4:0] == 5'h0a)
        wd_cnt_ff <= 12'h000;
      else if (fp_ff && !frame_pulse_n)
        wd_cnt_ff <= wd_cnt_ff + 12'h001;
      rise_age_ff <= ck_rise ? 6'h00 : rise_age_ff + {5'h00, rise_age_ff != 6'h3f};
      if (!tx_section_enable_n)
        off_bits_ff <= 2'h0;
      else if (ck_rise && off_bits_ff != 2'h3)
        off_bits_ff <= off_bits_ff + 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  rst_idle_a: assert property (disable iff (1'b0) !rstn |=> serial_data_out && !serial_data_out_oe
    && watchdog_alarm_n && !bus_data_oe) else $error("outputs not idle after reset");
  wd_rest_a: assert property (wd_cnt_ff >= 4 && wd_cnt_ff < 1024 |-> watchdog_alarm_n)
    else $error("alarm low too early");
  wd_fall_a: assert property ($fell(watchdog_alarm_n) |-> wd_cnt_ff == 1024)
    else $error("alarm fell at wrong frame count");
  wd_low_a: assert property (wd_cnt_ff >= 1028 && wd_cnt_ff < 2048 |-> !watchdog_alarm_n)
    else $error("alarm not low in second half");
  tx_gate_a: assert property (off_bits_ff != 2'h0 && rise_age_ff >= 6 |-> !serial_data_out_oe)
    else $error("output driven while disabled");
  sdo_edge_a: assert property ($changed(serial_data_out) && serial_data_out_oe && $past(serial_data_out_oe)
    |-> rise_age_ff >= 1 && rise_age_ff <= 6) else $error("output moved away from rising edge");
  status_zero_a: assert property (bus_data_oe && !bus_cs_n && bus_rw && bus_addr == `HSP_ADDR_FIFO_STATUS
    |-> bus_data_out[1:0] == 2'b00 && bus_data_out[7:6] == 2'b00) else $error("status fixed bits wrong");
  bus_idle_a: assert property ((bus_cs_n || !bus_rw) [*6] |-> !bus_data_oe)
    else $error("data bus driven without read");
  wd_cov_c: cover property ($fell(watchdog_alarm_n));
  rx_cov_c: cover property (bus_data_oe && bus_addr == `HSP_ADDR_BYTE_PORT);
  tx_cov_c: cover property ($rose(serial_data_out_oe));
endmodule
bind hsp_top hsp_properties u_hsp_properties (.mclk(mclk), .rstn(rstn), .serial_bit_clock_in(serial_bit_clock_in),
  .frame_pulse_n(frame_pulse_n), .tx_section_enable_n(tx_section_enable_n), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .watchdog_alarm_n(watchdog_alarm_n), .bus_e(bus_e), .bus_cs_n(bus_cs_n),
  .bus_rw(bus_rw), .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe));

// *** tb/hsp_link_model.sv ***
// far side of the serial link: makes the bit clock for n bits, sends pat lsb first, captures output
// assumes go rises once per burst; clock stands still between bursts
`timescale 1ns/1ps
module hsp_link_model (
  input wire go,
  input wire [7:0] n,
  input wire [7:0] pat,
  input wire serial_data_out,
  input wire serial_data_out_oe,
  output reg serial_bit_clock_in,
  output reg serial_data_in,
  output reg busy,
  output reg [31:0] cap
);
  integer i;
  initial begin
    serial_bit_clock_in = 1'b0;
    serial_data_in = 1'b0;
    busy = 1'b0;
    cap = 32'h0000_0000;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #7;
      for (i = 0; i < n; i = i + 1) begin
        serial_bit_clock_in = 1'b1;
        serial_data_in = pat[i % 8];
        #100 serial_bit_clock_in = 1'b0;
        // sync latency moves the output well past the rise, so it is taken at bit end
        #99 cap = {serial_data_out_oe ? serial_data_out : 1'bz, cap[31:1]};
        #1;
      end
      serial_data_in = ~serial_data_in;
      busy = 1'b0;
    end
  end
endmodule

// *** tb/hdlc_serial_port_fifo_status_bench.sv ***
// bench for hsp_top: transparent transfer both ways, fifo levels, watchdog
// assumes hsp_regs.vh on the include path; internal clocks unused here
`timescale 1ns/1ps
`include "hsp_regs.vh"
module hdlc_serial_port_fifo_status_bench;
  reg mclk, rstn, frame_pulse_n, tx_section_enable_n, rx_section_enable_n;
  reg bus_e, bus_cs_n, bus_rw, go;
  reg [3:0] bus_addr;
  reg [7:0] bus_data_in, n, pat, rd, a, b;
  wire serial_bit_clock_in, serial_data_in, serial_data_out, serial_data_out_oe, watchdog_alarm_n, bus_data_oe, busy;
  wire [7:0] bus_data_out;
  wire [31:0] cap;
  integer n_fail, check_count, seed, i, k;
  reg [7:0] rxq[$];
  hsp_top u_hsp_top (.mclk(mclk), .rstn(rstn), .serial_bit_clock_in(serial_bit_clock_in), .bus_clock_2m(1'b0),
    .bus_clock_4m_n(1'b1), .frame_pulse_n(frame_pulse_n), .tx_section_enable_n(tx_section_enable_n),
    .rx_section_enable_n(rx_section_enable_n), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .watchdog_alarm_n(watchdog_alarm_n), .bus_e(bus_e),
    .bus_cs_n(bus_cs_n), .bus_rw(bus_rw), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
  hsp_link_model u_hsp_link_model (.go(go), .n(n), .pat(pat), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .serial_bit_clock_in(serial_bit_clock_in),
    .serial_data_in(serial_data_in), .busy(busy), .cap(cap));
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // e high then low, 6 mclk each; address and data held past the fall
  task bus(input rw, input [3:0] ad, input [7:0] d);
    begin
      @(posedge mclk);
      bus_e <= 1'b1;
      bus_cs_n <= 1'b0;
      bus_rw <= rw;
      bus_addr <= ad;
      bus_data_in <= d;
      repeat (6) @(posedge mclk);
      rd = bus_data_out;
      bus_e <= 1'b0;
      repeat (6) @(posedge mclk);
      bus_cs_n <= 1'b1;
      bus_data_in <= ~d;
    end
  endtask
  task run(input [7:0] bits);
    begin
      @(posedge mclk);
      n <= bits;
      go <= 1'b1;
      repeat (2) @(posedge mclk);
      go <= 1'b0;
      for (k = 0; k < 2000 && busy !== 1'b0; k = k + 1)
        @(posedge mclk);
      if (k == 2000) begin
        n_fail = n_fail + 1;
        end_sim;
      end
    end
  endtask
  task pulses(input integer cnt);
    for (k = 0; k < cnt; k = k + 1) begin
      @(posedge mclk);
      frame_pulse_n <= 1'b0;
      repeat (4) @(posedge mclk);
      frame_pulse_n <= 1'b1;
      repeat (3) @(posedge mclk);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    seed = 13186;
    n_fail = 0;
    check_count = 0;
    rstn = 1'b0;
    frame_pulse_n = 1'b1;
    tx_section_enable_n = 1'b0;
    rx_section_enable_n = 1'b0;
    bus_e = 1'b0;
    bus_cs_n = 1'b1;
    bus_rw = 1'b1;
    bus_addr = 4'h0;
    bus_data_in = 8'h00;
    go = 1'b0;
    n = 8'h00;
    pat = 8'h00;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(1'b1, `HSP_ADDR_FIFO_STATUS, 8'h00);
    check(rd, 8'h08, "status reset");
    a = $random(seed);
    b = $random(seed);
    pat <= b;
    bus(1'b0, `HSP_ADDR_CONTROL, {4'h0, `HSP_FILL_TRANSP, 2'b00});
    bus(1'b0, `HSP_ADDR_BYTE_PORT, a);
    bus(1'b1, `HSP_ADDR_FIFO_STATUS, 8'h00);
    check(rd, 8'h08, "status lag");
    run(8'd32);
    check(cap, {a, a, a, 8'hff}, "tx bits");
    for (i = 0; i < 4; i = i + 1)
      rxq.push_back(b);
    bus(1'b1, `HSP_ADDR_FIFO_STATUS, 8'h00);
    check(rd, 8'h18, "status run");
    while (rxq.size() > 0) begin
      bus(1'b1, `HSP_ADDR_BYTE_PORT, 8'h00);
      check(rd, rxq.pop_front(), "rx byte");
    end
    // twenty pushes: the last finds the fifo full and is dropped
    for (i = 0; i < 20; i = i + 1)
      bus(1'b0, `HSP_ADDR_BYTE_PORT, $random(seed));
    tx_section_enable_n <= 1'b1;
    rx_section_enable_n <= 1'b1;
    run(8'd2);
    check(serial_data_out_oe, 1'b0, "tx gated");
    bus(1'b1, `HSP_ADDR_FIFO_STATUS, 8'h00);
    check(rd, 8'h00, "status full");
    // flag fill: the byte in the shifter finishes, then flags follow and the full fifo is not drained
    bus(1'b0, `HSP_ADDR_CONTROL, {4'h0, `HSP_FILL_FLAGS, 2'b00});
    tx_section_enable_n <= 1'b0;
    run(8'd16);
    check(cap[31:16], {`HSP_PAT_FLAG, a}, "tx flags");
    pulses(1020);
    check(watchdog_alarm_n, 1'b1, "alarm early");
    pulses(8);
    check(watchdog_alarm_n, 1'b0, "alarm low");
    bus(1'b0, `HSP_ADDR_WATCHDOG, 8'h0b);
    check(watchdog_alarm_n, 1'b0, "alarm wrong key");
    bus(1'b0, `HSP_ADDR_WATCHDOG, 8'hea);
    check(watchdog_alarm_n, 1'b1, "alarm cleared");
    end_sim;
  end
endmodule
